// ==== inc/swss_pkg.sv ====
/*
 * Shared constants and types of the second stop-mode wake source selector.
 * Assumes one 200 MHz clock and an AXI4-Lite register bus with 32-bit data.
 */
package swss_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_SELECT_ONE = 8'h0B;
    localparam logic [7:0] IDX_SELECT_TWO = 8'h0D;
    localparam logic [7:0] IDX_STATUS = 8'h10;
    localparam logic [7:0] ADDR_SELECT_ONE = {IDX_SELECT_ONE[5:0], 2'h0};
    localparam logic [7:0] ADDR_SELECT_TWO = {IDX_SELECT_TWO[5:0], 2'h0};
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'h0};

    // Field positions.
    localparam int SRC_LSB = 2;
    localparam int SRC_MSB = 4;
    localparam int LEVEL_BIT = 6;
    localparam int FLAG_BIT = 7;
    localparam int ST_STOP_BIT = 0;
    localparam int ST_PIN_WAKE_BIT = 1;
    localparam int ST_GATE_BIT = 2;
    localparam int ST_FLAG_BIT = 3;

    // Wake source codes.
    localparam logic [2:0] SRC_POR_ONLY = 3'h0;
    localparam logic [2:0] SRC_NAND_P2_LOW = 3'h1;
    localparam logic [2:0] SRC_NAND_P2_ALL = 3'h2;
    localparam logic [2:0] SRC_NOR_P3 = 3'h3;
    localparam logic [2:0] SRC_NAND_P3 = 3'h4;
    localparam logic [2:0] SRC_NOR_P3_P0 = 3'h5;
    localparam logic [2:0] SRC_NAND_P3_P0 = 3'h6;

    // Candidate line masks over {p0[7], p0[0], p3[3:1], p2[7:0]}.
    localparam logic [12:0] MASK_NONE = 13'h0000;
    localparam logic [12:0] MASK_P2_LOW = 13'h000F;
    localparam logic [12:0] MASK_P2_ALL = 13'h00FF;
    localparam logic [12:0] MASK_P3 = 13'h0700;
    localparam logic [12:0] MASK_P3_P0 = 13'h1F00;

    // Reset values.
    localparam logic [2:0] SRC_RESET = 3'h0;
    localparam logic LEVEL_RESET = 1'h0;
    localparam logic FLAG_RESET = 1'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SWSS_RUN = 2'h1,
        SWSS_STOP = 2'h2
    } swss_mode_t;

    typedef struct packed {
        swss_mode_t mode;
        logic [2:0] src;
        logic level;
        logic flag;
        logic wake_req;
        logic aw_got;
        logic [7:0] waddr;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] p2_s1;
        logic [7:0] p2_s2;
        logic [2:0] p3_s1;
        logic [2:0] p3_s2;
        logic [1:0] p0_s1;
        logic [1:0] p0_s2;
    } swss_state_t;

    localparam swss_state_t STATE_RESET = '{
        mode: SWSS_RUN,
        src: SRC_RESET,
        level: LEVEL_RESET,
        flag: FLAG_RESET,
        default: '0
    };

endpackage : swss_pkg

// ==== verilog/swss_top.sv ====
/*
 * Second stop-mode wake source selector with its AXI4-Lite register slave.
 * Assumes port pins arrive asynchronously, while direction bits, stop entry
 * and the first selector's wake event come from logic on the same clock.
 */
// Register access over AXI4-Lite was decided locally.
module swss_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [swss_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [swss_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [swss_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [swss_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] p2_pin,
    input wire logic [3:1] p3_pin,
    input wire logic [7:0] p0_pin,
    input wire logic [7:0] p2_dir_out,
    input wire logic [3:1] p3_dir_out,
    input wire logic [7:0] p0_dir_out,
    input wire logic stop_enter,
    input wire logic wake_event_one,
    output logic clk_run,
    output logic stop_active,
    output logic wake_req,
    output logic recovery_flag
);
    import swss_pkg::*;

    swss_state_t s_reg;
    swss_state_t s_next;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic have_aw;
    logic have_w;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_strb0;
    logic [12:0] cand;
    logic [12:0] dirv;
    logic [12:0] mask;
    logic [12:0] incl;
    logic use_nand;
    logic gate_out;
    logic gate_valid;
    logic pin_wake;
    logic wake_any;

    assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign clk_run = (s_reg.mode == SWSS_RUN);
    assign stop_active = (s_reg.mode == SWSS_STOP);
    assign wake_req = s_reg.wake_req;
    assign recovery_flag = s_reg.flag;

    // Wake gate built from the synchronised pins.
    always_comb begin
        cand = {s_reg.p0_s2[1], s_reg.p0_s2[0], s_reg.p3_s2, s_reg.p2_s2};
        dirv = {p0_dir_out[7], p0_dir_out[0], p3_dir_out, p2_dir_out};
        use_nand = 1'b1;
        unique case (s_reg.src)
            SRC_NAND_P2_LOW: mask = MASK_P2_LOW;
            SRC_NAND_P2_ALL: mask = MASK_P2_ALL;
            SRC_NOR_P3: begin
                mask = MASK_P3;
                use_nand = 1'b0;
            end
            SRC_NAND_P3: mask = MASK_P3;
            SRC_NOR_P3_P0: begin
                mask = MASK_P3_P0;
                use_nand = 1'b0;
            end
            SRC_NAND_P3_P0: mask = MASK_P3_P0;
            default: mask = MASK_NONE;
        endcase
        // Lines driven as outputs are removed before the gate.
        incl = mask & ~dirv;
        gate_valid = |incl;
        if (use_nand) begin
            gate_out = ~&(cand | ~incl);
        end else begin
            gate_out = ~|(cand & incl);
        end
        // The level bit decides which gate level counts as a wake.
        pin_wake = gate_valid && (s_reg.level ? gate_out : !gate_out);
        wake_any = pin_wake || wake_event_one;
    end

    always_comb begin
        s_next = s_reg;
        s_next.wake_req = 1'b0;

        s_next.p2_s1 = p2_pin;
        s_next.p2_s2 = s_reg.p2_s1;
        s_next.p3_s1 = p3_pin;
        s_next.p3_s2 = s_reg.p3_s1;
        s_next.p0_s1 = {p0_pin[7], p0_pin[0]};
        s_next.p0_s2 = s_reg.p0_s1;

        aw_fire = s_axi_awvalid && s_axi_awready;
        w_fire = s_axi_wvalid && s_axi_wready;
        ar_fire = s_axi_arvalid && s_axi_arready;
        have_aw = s_reg.aw_got || aw_fire;
        have_w = s_reg.w_got || w_fire;
        wr_addr = s_reg.aw_got ? s_reg.waddr : s_axi_awaddr;
        wr_data = s_reg.w_got ? s_reg.wdata : s_axi_wdata[7:0];
        wr_strb0 = s_reg.w_got ? s_reg.wstrb0 : s_axi_wstrb[0];

        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (aw_fire) begin
            s_next.aw_got = 1'b1;
            s_next.waddr = s_axi_awaddr;
        end
        if (w_fire) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata[7:0];
            s_next.wstrb0 = s_axi_wstrb[0];
        end
        if (have_aw && have_w) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            if (wr_addr == ADDR_SELECT_TWO) begin
                // Reserved bits are dropped; software is expected to send zeros.
                if (wr_strb0) begin
                    s_next.src = wr_data[SRC_MSB:SRC_LSB];
                    s_next.level = wr_data[LEVEL_BIT];
                end
            end else if (wr_addr != ADDR_SELECT_ONE && wr_addr != ADDR_STATUS) begin
                s_next.bresp = RESP_SLVERR;
            end
        end

        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (ar_fire) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = '0;
            s_next.rresp = RESP_OKAY;
            if (s_axi_araddr == ADDR_SELECT_ONE) begin
                s_next.rdata[FLAG_BIT] = s_reg.flag;
            end else if (s_axi_araddr == ADDR_STATUS) begin
                s_next.rdata[ST_STOP_BIT] = (s_reg.mode == SWSS_STOP);
                s_next.rdata[ST_PIN_WAKE_BIT] = pin_wake;
                s_next.rdata[ST_GATE_BIT] = gate_out && gate_valid;
                s_next.rdata[ST_FLAG_BIT] = s_reg.flag;
            end else if (s_axi_araddr != ADDR_SELECT_TWO) begin
                // The selector register itself is write only and reads as zero.
                s_next.rresp = RESP_SLVERR;
            end
        end

        unique case (s_reg.mode)
            SWSS_RUN: begin
                if (stop_enter) begin
                    s_next.mode = SWSS_STOP;
                end
            end
            SWSS_STOP: begin
                if (wake_any) begin
                    s_next.mode = SWSS_RUN;
                    s_next.wake_req = 1'b1;
                    s_next.flag = 1'b1;
                end
            end
            default: s_next.mode = SWSS_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule : swss_top

// ==== tb/swss_pins.sv ====
/*
 * Model of the port pins that feed the wake selector.
 * Assumes the bench sets the wanted line levels just after a clock edge.
 */
module swss_pins (
    input wire logic [12:0] want,
    input wire logic [7:0] p2_dir_out,
    output logic [7:0] p2_pin,
    output logic [3:1] p3_pin,
    output logic [7:0] p0_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // A port 2 line set as an output carries the device's own low level.
    assign p2_pin = want[7:0] & ~p2_dir_out;
    assign p3_pin = want[10:8];
    assign p0_pin = {want[12], 6'h00, want[11]};
endmodule : swss_pins

// ==== tb/swss_chk.sv ====
/*
 * Assertions on the stop, wake and bus answer ports of the selector.
 * Assumes it is bound into the top module and sees its ports by name.
 */
module swss_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stop_enter,
    input wire logic wake_event_one,
    input wire logic clk_run,
    input wire logic stop_active,
    input wire logic wake_req,
    input wire logic recovery_flag,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_enter;
        clk_run && stop_enter ##1 stop_active;
    endsequence
    property p_inv; clk_run != stop_active; endproperty
    property p_enter; clk_run && stop_enter |-> s_enter; endproperty
    property p_either; stop_active && wake_event_one |=> wake_req && clk_run; endproperty
    property p_pulse; wake_req |=> !wake_req; endproperty
    property p_cause; wake_req |-> $past(stop_active) && clk_run; endproperty
    property p_flag; wake_req |-> recovery_flag; endproperty
    property p_sticky; recovery_flag |=> recovery_flag; endproperty
    property p_run; clk_run |=> !wake_req; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_inv: assert property (p_inv) else $error("clock run and stop disagree");
    a_enter: assert property (p_enter) else $error("stop not entered");
    a_either: assert property (p_either) else $error("first event no wake");
    a_pulse: assert property (p_pulse) else $error("wake request too long");
    a_cause: assert property (p_cause) else $error("wake without stop");
    a_flag: assert property (p_flag) else $error("flag not set on wake");
    a_sticky: assert property (p_sticky) else $error("flag cleared");
    a_run: assert property (p_run) else $error("wake while running");
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule : swss_chk

bind swss_top swss_chk u_chk (.*);

// ==== tb/tb_top.sv ====
/*
 * Bench for the wake selector: bus tasks, a source table and stop cycles.
 * Assumes the design answers each bus request within fifty cycles.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import swss_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, stop_enter = 1'b0, wake_event_one = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, p2_dir_out = 8'h00;
    logic [7:0] p0_dir_out = 8'h00, p2_pin, p0_pin;
    logic [3:1] p3_dir_out = 3'h0, p3_pin;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic clk_run, stop_active, wake_req, recovery_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [12:0] want = 13'h0000;
    int errors = 0, checks = 0;
    // Source code, level, idle lines, waking lines over {p0[7], p0[0], p3, p2}.
    localparam logic [29:0] ROWS [7] = '{
        {SRC_NAND_P2_LOW, 1'b0, 13'h0000, 13'h000E}, {SRC_NAND_P2_ALL, 1'b0, 13'h007F, 13'h00FF},
        {SRC_NOR_P3, 1'b0, 13'h0000, 13'h0400}, {SRC_NAND_P3, 1'b1, 13'h0700, 13'h0600},
        {SRC_NOR_P3_P0, 1'b0, 13'h0000, 13'h1000}, {SRC_NAND_P3_P0, 1'b0, 13'h0F00, 13'h1F00},
        {SRC_NOR_P3, 1'b1, 13'h0100, 13'h0000}};
    swss_top u_dut (.*);
    swss_pins u_pins (.want(want), .p2_dir_out(p2_dir_out), .p2_pin(p2_pin), .p3_pin(p3_pin),
        .p0_pin(p0_pin));
    task automatic final_report;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        // One edge between calls keeps a ready release and the next raise apart.
        @(posedge clk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (w ? s_axi_bvalid : s_axi_rvalid) break;
        end
        q = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n == 50) begin
            errors++;
            final_report();
        end
    endtask : bus
    task automatic stop_wake(input logic [12:0] wl, input logic ev);
        int n;
        repeat (4) @(posedge clk);
        stop_enter <= 1'b1;
        @(posedge clk);
        stop_enter <= 1'b0;
        repeat (8) @(posedge clk);
        chk("stopped", stop_active, 1'b1);
        want <= wl;
        wake_event_one <= ev;
        for (n = 0; n < 20 && wake_req !== 1'b1; n++) @(posedge clk);
        wake_event_one <= 1'b0;
        chk("woke", {wake_req, clk_run}, 2'h3);
        if (n == 20) final_report();
    endtask : stop_wake
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        bus(0, ADDR_SELECT_TWO, 32'h0);
        chk("select_two", {q, r}, {32'h0, RESP_OKAY});
        bus(0, 8'h08, 32'h0);
        chk("unmapped", r, RESP_SLVERR);
        want <= 13'h1FFF;
        stop_wake(13'h1FFF, 1'b1);
        for (int i = 0; i < 7; i++) begin
            p2_dir_out <= (i == 0) ? 8'h01 : 8'h00;
            want <= ROWS[i][25:13];
            bus(1, ADDR_SELECT_TWO, {25'h0, ROWS[i][26], 1'b0, ROWS[i][29:27], 2'h0});
            chk("write_resp", r, RESP_OKAY);
            stop_wake(ROWS[i][12:0], 1'b0);
        end
        bus(0, ADDR_STATUS, 32'h0);
        chk("status", {q[3], q[0]}, 2'h2);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        bus(0, ADDR_SELECT_ONE, 32'h0);
        chk("flag", q[7], 1'b0);
        final_report();
    end
endmodule : tb_top
